// ### src/dbic_pkg.sv
package dbic_pkg;
    // Bus offsets (byte address within the board's slot)
    localparam logic [4:0] CONFIG_ONE_OFFSET    = 5'h0A;
    localparam logic [4:0] IRQ_ONE_CLEAR_OFFSET = 5'h02;
    localparam logic [4:0] IRQ_TWO_CLEAR_OFFSET = 5'h04;
    localparam logic [4:0] DMA_TC_CLEAR_OFFSET  = 5'h00;
    // Field positions in board_config_one
    localparam int EXT_IRQ_TWO_EN_BIT       = 15;
    localparam int EXT_IRQ_ONE_EN_BIT       = 14;
    localparam int CNT_IRQ_TWO_EN_BIT       = 13;
    localparam int CNT_IRQ_ONE_EN_BIT       = 12;
    localparam int CNT_ONE_SRC_BIT          = 10;
    localparam int CNT_TWO_SRC_BIT          = 9;
    localparam int ALT_BANK_BIT             = 7;
    localparam int GRP_ONE_UPD_SRC_BIT      = 6;
    localparam int CHAN_SEL_LSB             = 0;
    localparam int CHAN_SEL_W               = 4;
    localparam logic [15:0] CONFIG_ONE_RESET = 16'h0000;
    // Width of the internal external-update low pulse
    localparam int EXT_PULSE_NS             = 200;
    localparam int CLK_PERIOD_NS            = 100;
    localparam int EXT_PULSE_CYC            =
        (EXT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        DBIC_PS_IDLE  = 2'b00,
        DBIC_PS_LOW   = 2'b01,
        DBIC_PS_REARM = 2'b11
    } dbic_pulse_state_t;
endpackage

// ### src/dbic_evt_if.sv
`timescale 1ns/1ps
interface dbic_evt_if;
    logic clr;
    logic set_a;
    logic set_b;
    logic flag;
    modport owner (input clr, input set_a, input set_b, output flag);
    modport user  (output clr, output set_a, output set_b, input flag);
endinterface

// ### src/dbic_sticky_flag.sv
`timescale 1ns/1ps
module dbic_sticky_flag (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    dbic_evt_if.owner   evt
);
    logic flag;
    logic next_flag;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        next_flag = flag;
        if (evt.clr) begin
            next_flag = 1'b0;
        end
        if (evt.set_a || evt.set_b) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    assign evt.flag = flag;

    a_set_holds_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (evt.set_a || evt.set_b) |=> flag)
        else $error("sticky flag did not set");
    a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag && !evt.clr) |=> flag)
        else $error("flag dropped without clear");
endmodule

// ### src/dbic_pulse_gen.sv
`timescale 1ns/1ps
module dbic_pulse_gen #(
    parameter int PULSE_CYC = dbic_pkg::EXT_PULSE_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_fall,
    output logic      o_pulse_n,
    output logic      o_rise
);
    dbic_pkg::dbic_pulse_state_t state;
    dbic_pkg::dbic_pulse_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            dbic_pkg::DBIC_PS_IDLE: begin
                if (i_fall) begin
                    next_state = dbic_pkg::DBIC_PS_LOW;
                    next_cnt   = 8'(PULSE_CYC - 1);
                end
            end
            dbic_pkg::DBIC_PS_LOW: begin
                if (cnt == 8'h00) begin
                    next_state = dbic_pkg::DBIC_PS_REARM;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            dbic_pkg::DBIC_PS_REARM: begin
                next_state = dbic_pkg::DBIC_PS_IDLE;
            end
            default: begin
                next_state = dbic_pkg::DBIC_PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= dbic_pkg::DBIC_PS_IDLE;
            cnt   <= 8'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign o_pulse_n = (state != dbic_pkg::DBIC_PS_LOW);
    // Rising edge of the pulse is the cycle the low phase ends
    assign o_rise    = (state == dbic_pkg::DBIC_PS_LOW) && (cnt == 8'h00);
endmodule

// ### src/dbic_top.sv
// What this block does
// - Config register is write-only, 16 bits, offset 0A, word writes only.
// - All configuration bits clear to zero at reset.
// - Unused bits are ignored on write; reads of the register return arbitrary data.
// - Alternate bank bit steers shared-address writes to clear registers or primary ones.
// - Bit 15: external falling edge makes low pulse; its rise requests interrupt two.
// - Interrupt two stays pending until the interrupt-two clear register is written.
// - Bit 15: the external pulse also strobes DAC group two updates.
// - Bit 14: external pulse rise requests interrupt one.
// - Interrupt one stays pending until the interrupt-one clear register is written.
// - Bit 13: rising edge of counter-two low output requests interrupt two.
// - Bit 13: counter-two low pulse also strobes DAC group two.
// - Bit 12: rising edge of counter-one low output requests interrupt one.
// - Bit 6 picks external pulse, else counter-one output, as group-one update.
// - Bits 10 and 9 pick counter sources: 1-MHz clock or counter three.
`timescale 1ns/1ps
module dbic_top (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [4:0]  i_io_addr,
    input  wire logic [15:0] i_io_wdata,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_word,
    input  wire logic        i_external_update_in_n,
    input  wire logic        i_counter_one_out_n,
    input  wire logic        i_counter_two_out_n,
    output logic             o_irq_one,
    output logic             o_irq_two,
    output logic             o_external_update_pulse_n,
    output logic             o_group_one_update_n,
    output logic             o_group_two_update_n,
    output logic [3:0]       o_channel_select,
    output logic             o_counter_one_source_sel,
    output logic             o_counter_two_source_sel,
    output logic             o_alt_bank_write_select,
    output logic             o_dma_terminal_clear
);
    logic        rst_meta_n;
    logic        rst_n;
    logic [15:0] board_config_one;
    logic [15:0] next_board_config_one;
    logic        cfg_wr;
    logic        irq_one_clear;
    logic        irq_two_clear;
    logic        dma_terminal_clear;
    logic [2:0]  sync_meta;
    logic [2:0]  sync_q;
    logic [2:0]  sync_prev;
    logic        ext_fall;
    logic        cnt_one_rise;
    logic        cnt_two_rise;
    logic        ext_pulse_n;
    logic        ext_rise;
    logic        grp_one_upd_n;
    logic        grp_two_upd_n;

    // Reset is released through two flip-flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Address decode shared by every write strobe
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    assign cfg_wr = i_io_wr && i_io_word && hit(i_io_addr, dbic_pkg::CONFIG_ONE_OFFSET);
    // Clear strobes respond only while the alternate bank is selected
    assign irq_one_clear = i_io_wr && board_config_one[dbic_pkg::ALT_BANK_BIT]
        && hit(i_io_addr, dbic_pkg::IRQ_ONE_CLEAR_OFFSET);
    assign irq_two_clear = i_io_wr && board_config_one[dbic_pkg::ALT_BANK_BIT]
        && hit(i_io_addr, dbic_pkg::IRQ_TWO_CLEAR_OFFSET);
    assign dma_terminal_clear = i_io_wr && board_config_one[dbic_pkg::ALT_BANK_BIT]
        && hit(i_io_addr, dbic_pkg::DMA_TC_CLEAR_OFFSET);

    // Whole word stored; undriven fields have no consumer so their value is inert
    always_comb begin
        next_board_config_one = board_config_one;
        if (cfg_wr) begin
            next_board_config_one = i_io_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            board_config_one <= dbic_pkg::CONFIG_ONE_RESET;
        end else begin
            board_config_one <= next_board_config_one;
        end
    end

    // Pin inputs: two-stage synchronisers, edges taken after the second stage
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= 3'b111;
            sync_q    <= 3'b111;
            sync_prev <= 3'b111;
        end else begin
            sync_meta <= {i_counter_two_out_n, i_counter_one_out_n, i_external_update_in_n};
            sync_q    <= sync_meta;
            sync_prev <= sync_q;
        end
    end

    assign ext_fall     = sync_prev[0] && !sync_q[0];
    assign cnt_one_rise = !sync_prev[1] && sync_q[1];
    assign cnt_two_rise = !sync_prev[2] && sync_q[2];

    dbic_pulse_gen u_pulse (
        .i_clk     (i_clk),
        .i_rst_n   (rst_n),
        .i_fall    (ext_fall),
        .o_pulse_n (ext_pulse_n),
        .o_rise    (ext_rise)
    );

    dbic_evt_if irq_one_evt ();
    dbic_evt_if irq_two_evt ();

    assign irq_one_evt.clr   = irq_one_clear;
    assign irq_one_evt.set_a = ext_rise && board_config_one[dbic_pkg::EXT_IRQ_ONE_EN_BIT];
    assign irq_one_evt.set_b = cnt_one_rise
        && board_config_one[dbic_pkg::CNT_IRQ_ONE_EN_BIT];
    assign irq_two_evt.clr   = irq_two_clear;
    assign irq_two_evt.set_a = ext_rise && board_config_one[dbic_pkg::EXT_IRQ_TWO_EN_BIT];
    assign irq_two_evt.set_b = cnt_two_rise
        && board_config_one[dbic_pkg::CNT_IRQ_TWO_EN_BIT];

    dbic_sticky_flag u_irq_one (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .evt     (irq_one_evt)
    );

    dbic_sticky_flag u_irq_two (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .evt     (irq_two_evt)
    );

    // Update strobes, active low
    always_comb begin
        grp_one_upd_n = board_config_one[dbic_pkg::GRP_ONE_UPD_SRC_BIT]
            ? ext_pulse_n : sync_q[1];
        grp_two_upd_n = 1'b1;
        if (board_config_one[dbic_pkg::EXT_IRQ_TWO_EN_BIT] && !ext_pulse_n) begin
            grp_two_upd_n = 1'b0;
        end
        if (board_config_one[dbic_pkg::CNT_IRQ_TWO_EN_BIT] && !sync_q[2]) begin
            grp_two_upd_n = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_group_one_update_n      <= 1'b1;
            o_group_two_update_n      <= 1'b1;
            o_external_update_pulse_n <= 1'b1;
            o_dma_terminal_clear      <= 1'b0;
        end else begin
            o_group_one_update_n      <= grp_one_upd_n;
            o_group_two_update_n      <= grp_two_upd_n;
            o_external_update_pulse_n <= ext_pulse_n;
            o_dma_terminal_clear      <= dma_terminal_clear;
        end
    end

    assign o_irq_one                = irq_one_evt.flag;
    assign o_irq_two                = irq_two_evt.flag;
    assign o_channel_select         = board_config_one[dbic_pkg::CHAN_SEL_LSB +: dbic_pkg::CHAN_SEL_W];
    assign o_counter_one_source_sel = board_config_one[dbic_pkg::CNT_ONE_SRC_BIT];
    assign o_counter_two_source_sel = board_config_one[dbic_pkg::CNT_TWO_SRC_BIT];
    assign o_alt_bank_write_select  = board_config_one[dbic_pkg::ALT_BANK_BIT];

    sequence s_ext_fall_seen;
        ext_fall;
    endsequence

    a_cfg_byte_ignored: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_io_wr && !i_io_word) |=> $stable(board_config_one))
        else $error("byte write changed config");
    a_cfg_word_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        cfg_wr |=> board_config_one == $past(i_io_wdata))
        else $error("config word not stored");
    a_reset_cleared: assert property (@(posedge i_clk)
        !rst_n |-> board_config_one == 16'h0000)
        else $error("config not cleared in reset");
    a_clear_needs_bank: assert property (@(posedge i_clk) disable iff (!rst_n)
        (irq_one_clear || irq_two_clear) |-> o_alt_bank_write_select)
        else $error("clear taken in primary bank");
    a_ext_irq_two: assert property (@(posedge i_clk) disable iff (!rst_n)
        (s_ext_fall_seen ##0 board_config_one[15] ##1 board_config_one[15][*2])
        |=> o_irq_two)
        else $error("ext event did not raise irq two");
    a_irq_two_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (o_irq_two && !irq_two_clear) |=> o_irq_two)
        else $error("irq two dropped without clear");
    a_irq_two_clr: assert property (@(posedge i_clk) disable iff (!rst_n)
        (irq_two_clear && !irq_two_evt.set_a && !irq_two_evt.set_b) |=> !o_irq_two)
        else $error("irq two not cleared");
    a_ext_irq_one: assert property (@(posedge i_clk) disable iff (!rst_n)
        (s_ext_fall_seen ##0 board_config_one[14] ##1 board_config_one[14][*2])
        |=> o_irq_one)
        else $error("ext event did not raise irq one");
    a_irq_one_clr: assert property (@(posedge i_clk) disable iff (!rst_n)
        (irq_one_clear && !irq_one_evt.set_a && !irq_one_evt.set_b) |=> !o_irq_one)
        else $error("irq one not cleared");
    a_cnt_two_irq: assert property (@(posedge i_clk) disable iff (!rst_n)
        (cnt_two_rise && board_config_one[13]) |=> o_irq_two)
        else $error("counter two rise lost");
    a_cnt_one_irq: assert property (@(posedge i_clk) disable iff (!rst_n)
        (cnt_one_rise && board_config_one[12]) |=> o_irq_one)
        else $error("counter one rise lost");
    a_grp_two_strobe: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!board_config_one[15] && !board_config_one[13]) |=> o_group_two_update_n)
        else $error("group two strobe without source");
    a_grp_one_src: assert property (@(posedge i_clk) disable iff (!rst_n)
        !board_config_one[6] |=> o_group_one_update_n == $past(sync_q[1]))
        else $error("group one source wrong");

    // Pulse steps: a fall taken while idle, then a fixed low phase, then release
    sequence s_pulse_from_idle;
        ext_fall && (u_pulse.state == dbic_pkg::DBIC_PS_IDLE);
    endsequence

    sequence s_pulse_low_phase;
        !ext_pulse_n [*2] ##1 ext_pulse_n;
    endsequence

    sequence s_rise_ends_low;
        !ext_pulse_n ##1 ext_pulse_n;
    endsequence

    a_ext_pulse_width: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_pulse_from_idle
        |=> s_pulse_low_phase)
        else $error("external pulse width wrong");
    a_ext_rise_end: assert property (@(posedge i_clk) disable iff (!rst_n)
        ext_rise
        |-> s_rise_ends_low)
        else $error("pulse rise not at end of low phase");
    a_ext_out_copy: assert property (@(posedge i_clk) disable iff (!rst_n)
        1'b1
        |=> o_external_update_pulse_n == $past(ext_pulse_n))
        else $error("pulse output not registered copy");
    a_irq_one_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (o_irq_one && !irq_one_clear)
        |=> o_irq_one)
        else $error("irq one dropped without clear");
    a_irq_one_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!o_irq_one && !irq_one_evt.set_a && !irq_one_evt.set_b)
        |=> !o_irq_one)
        else $error("irq one raised without source");
    a_irq_two_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!o_irq_two && !irq_two_evt.set_a && !irq_two_evt.set_b)
        |=> !o_irq_two)
        else $error("irq two raised without source");
    a_bank_refuses: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_io_wr && !o_alt_bank_write_select)
        |-> !(irq_one_clear || irq_two_clear || dma_terminal_clear))
        else $error("clear taken in primary bank");
    a_dma_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
        dma_terminal_clear
        |=> o_dma_terminal_clear)
        else $error("dma clear pulse missing");
    a_dma_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
        !dma_terminal_clear
        |=> !o_dma_terminal_clear)
        else $error("dma clear pulse without write");
    a_cfg_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        !cfg_wr
        |=> $stable(board_config_one))
        else $error("config changed without word write");
    a_cnt_src_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        cfg_wr
        |=> o_counter_one_source_sel == $past(i_io_wdata[dbic_pkg::CNT_ONE_SRC_BIT]))
        else $error("counter one source not loaded");
    a_cnt_two_src_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        cfg_wr
        |=> o_counter_two_source_sel == $past(i_io_wdata[dbic_pkg::CNT_TWO_SRC_BIT]))
        else $error("counter two source not loaded");
    a_grp_one_ext: assert property (@(posedge i_clk) disable iff (!rst_n)
        board_config_one[dbic_pkg::GRP_ONE_UPD_SRC_BIT]
        |=> o_group_one_update_n == $past(ext_pulse_n))
        else $error("group one not fed by external pulse");
    a_grp_two_ext: assert property (@(posedge i_clk) disable iff (!rst_n)
        (board_config_one[dbic_pkg::EXT_IRQ_TWO_EN_BIT] && !ext_pulse_n)
        |=> !o_group_two_update_n)
        else $error("group two missed external strobe");
    a_grp_two_cnt: assert property (@(posedge i_clk) disable iff (!rst_n)
        (board_config_one[dbic_pkg::CNT_IRQ_TWO_EN_BIT] && !sync_q[2])
        |=> !o_group_two_update_n)
        else $error("group two missed counter strobe");
endmodule

// ### bench/dbic_host_model.sv
`timescale 1ns/1ps
module dbic_host_model (
    input  wire logic   i_clk,
    output logic [4:0]  o_addr,
    output logic [15:0] o_wdata,
    output logic        o_wr,
    output logic        o_word
);
    initial begin
        o_addr  = 5'h1F;
        o_wdata = 16'h0000;
        o_wr    = 1'b0;
        o_word  = 1'b0;
    end

    // One strobe cycle per write; address, data and width stay put through the taking edge
    task automatic host_write(input logic [4:0] addr, input logic [15:0] data, input logic word);
        @(posedge i_clk);
        o_addr  <= addr;
        o_wdata <= data;
        o_word  <= word;
        o_wr    <= 1'b1; // Pending requests end only by a write to their clear register
        @(posedge i_clk);
        o_wr    <= 1'b0;
        // Released bus shows inverted values so nothing stale looks like a fresh request
        o_addr  <= ~addr;
        o_wdata <= ~data;
        o_word  <= ~word;
    endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        reset_n;
    logic        ext_n;
    logic        cnt1_n;
    logic        cnt2_n;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        word;
    logic        irq_one;
    logic        irq_two;
    logic        ext_pulse_n;
    logic        g1_n;
    logic        g2_n;
    logic [3:0]  chan;
    logic        cnt1_src;
    logic        cnt2_src;
    logic        alt;
    logic        dma_clr;
    int          n_mismatch;
    int          checked;
    int          cycles;
    int          seed;
    int          exp_cfg;
    int          exp_irq1;
    int          exp_irq2;
    int          exp_dma;
    int          n_dma;
    int          ext_low;
    int          g1_low;
    int          g2_low;
    logic [15:0] cfgs [5] = '{16'hC040, 16'h2000, 16'h1000, 16'hF000, 16'h0000};

    dbic_top u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_io_addr(addr), .i_io_wdata(wdata),
        .i_io_wr(wr), .i_io_word(word), .i_external_update_in_n(ext_n),
        .i_counter_one_out_n(cnt1_n), .i_counter_two_out_n(cnt2_n), .o_irq_one(irq_one),
        .o_irq_two(irq_two), .o_external_update_pulse_n(ext_pulse_n),
        .o_group_one_update_n(g1_n), .o_group_two_update_n(g2_n), .o_channel_select(chan),
        .o_counter_one_source_sel(cnt1_src), .o_counter_two_source_sel(cnt2_src),
        .o_alt_bank_write_select(alt), .o_dma_terminal_clear(dma_clr));

    dbic_host_model u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_word(word));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (dma_clr === 1'b1) n_dma++;
        if (ext_pulse_n === 1'b0) ext_low++;
        if (g1_n === 1'b0) g1_low++;
        if (g2_n === 1'b0) g2_low++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_all;
        chk(16'(chan), 16'(exp_cfg[3:0]));
        chk(16'({cnt1_src, cnt2_src, alt}), 16'({exp_cfg[10], exp_cfg[9], exp_cfg[7]}));
        chk(16'({irq_one, irq_two}), 16'({exp_irq1[0], exp_irq2[0]}));
        chk(16'(n_dma), 16'(exp_dma));
    endtask

    task automatic wr_chk(input logic [4:0] a, input logic [15:0] d, input logic w);
        u_host.host_write(a, d, w);
        if (w && a == dbic_pkg::CONFIG_ONE_OFFSET) exp_cfg = int'(d);
        else if (exp_cfg[dbic_pkg::ALT_BANK_BIT] == 1) begin
            if (a == dbic_pkg::IRQ_ONE_CLEAR_OFFSET) exp_irq1 = 0;
            if (a == dbic_pkg::IRQ_TWO_CLEAR_OFFSET) exp_irq2 = 0;
            if (a == dbic_pkg::DMA_TC_CLEAR_OFFSET) exp_dma++;
        end
        repeat (3) @(posedge clk);
        chk_all;
    endtask

    // which: 0 external update pin, 1 counter one, 2 counter two
    task automatic strike(input int which);
        ext_low = 0;
        g1_low = 0;
        g2_low = 0;
        @(posedge clk);
        if (which == 0) ext_n <= 1'b0;
        else if (which == 1) cnt1_n <= 1'b0;
        else cnt2_n <= 1'b0;
        repeat (5) @(posedge clk);
        ext_n <= 1'b1;
        cnt1_n <= 1'b1;
        cnt2_n <= 1'b1;
        repeat (12) @(posedge clk);
        if ((which == 0 && exp_cfg[15] == 1) || (which == 2 && exp_cfg[13] == 1)) exp_irq2 = 1;
        if ((which == 0 && exp_cfg[14] == 1) || (which == 1 && exp_cfg[12] == 1)) exp_irq1 = 1;
        chk_all;
        if (which == 0 && exp_cfg[15:14] != 0) chk(16'(ext_low), 16'(dbic_pkg::EXT_PULSE_CYC));
        chk(16'(g1_low > 0), 16'((which == 0 && exp_cfg[6]) || (which == 1 && !exp_cfg[6])));
        chk(16'(g2_low > 0), 16'((which == 0 && exp_cfg[15]) || (which == 2 && exp_cfg[13])));
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        seed = 25869;
        reset_n = 1'b0;
        ext_n = 1'b1;
        cnt1_n = 1'b1;
        cnt2_n = 1'b1;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_all;
        chk(16'({g1_n, g2_n, ext_pulse_n}), 16'h0007);
        for (int i = 0; i < 6; i++) begin
            wr_chk(dbic_pkg::CONFIG_ONE_OFFSET, 16'($random(seed)) & 16'h0FFF, 1'b1);
        end
        wr_chk(dbic_pkg::CONFIG_ONE_OFFSET, 16'hFFFF, 1'b0);
        wr_chk(dbic_pkg::CONFIG_ONE_OFFSET, 16'h0000, 1'b1);
        wr_chk(dbic_pkg::DMA_TC_CLEAR_OFFSET, 16'($random(seed)), 1'b1);
        foreach (cfgs[k]) begin
            wr_chk(dbic_pkg::CONFIG_ONE_OFFSET, cfgs[k], 1'b1);
            for (int w = 0; w < 3; w++) begin
                strike(w);
            end
            wr_chk(dbic_pkg::IRQ_TWO_CLEAR_OFFSET, 16'($random(seed)), 1'b1);
            wr_chk(dbic_pkg::CONFIG_ONE_OFFSET, cfgs[k] | 16'h0080, 1'b1);
            wr_chk(dbic_pkg::IRQ_ONE_CLEAR_OFFSET, 16'($random(seed)), 1'b1);
            wr_chk(dbic_pkg::IRQ_TWO_CLEAR_OFFSET, 16'($random(seed)), 1'b0);
            wr_chk(dbic_pkg::DMA_TC_CLEAR_OFFSET, 16'($random(seed)), 1'b1);
        end
        test_done;
    end
endmodule
